/* File: hw/poll_scan_pkg.sv */
// Constants for the periodic poll table scanner
// How it works
// - Each port owns a 48-entry read/write table
// - Messages spaced by interval in 10 ms units
// - Reply still pending adds two seconds wait
// - Interval zero disables the whole table
// - Local start valid 1..32 or 65..2048
// - Remote start valid 1..65535, zero disables
// - Count valid 1..128, zero disables entry
// - Read stores at local; write sends from local
// - Only fully valid entries are issued
// - Any valid entry suppresses fixed-route transfer
// - Polling in master mode refuses slave answers
// - Status bit set on success, cleared otherwise
// - Status packed in three 16-bit words
// - Mask low five bits select watchdog ports
// - Timer write restarts countdown in 10 ms
// - Expiry stops masked ports, clears their status
// - Timer resets to zero, masked ports shut
// - Route is a list of drop numbers
package poll_scan_pkg;
  localparam int ENTRIES = 48;
  localparam int TICK_MS = 10;
  localparam int CLK_MHZ = 100;
  localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
  localparam int STALL_MS = 2000;
  localparam int STALL_TICKS = STALL_MS / TICK_MS;
  localparam logic [11:0] LOCAL_LO_MAX = 12'h020;
  localparam logic [11:0] LOCAL_HI_MIN = 12'h041;
  localparam logic [11:0] LOCAL_HI_MAX = 12'h800;
  localparam logic [7:0] COUNT_MAX = 8'h80;
  localparam logic [15:0] WD_TIMER_RST = 16'h0000;
  localparam logic [4:0] WD_MASK_RST = 5'h00;
  // APB byte addresses; watchdog registers sit at index times four
  localparam logic [15:0] IDX_WD_TIMER = 16'h1ffd;
  localparam logic [15:0] IDX_WD_MASK = 16'h1ffe;
  localparam logic [15:0] ADDR_WD_TIMER = 16'h7ff4;
  localparam logic [15:0] ADDR_WD_MASK = 16'h7ff8;
  localparam logic [15:0] ADDR_CTRL = 16'h0000;
  localparam logic [15:0] ADDR_STATUS0 = 16'h0004;
  localparam logic [15:0] ADDR_STATUS1 = 16'h0008;
  localparam logic [15:0] ADDR_STATUS2 = 16'h000c;
  localparam logic [15:0] ADDR_ENT_SEL = 16'h0010;
  localparam logic [15:0] ADDR_ENT_A = 16'h0014;
  localparam logic [15:0] ADDR_ENT_B = 16'h0018;
  localparam logic [15:0] ADDR_ENT_ROUTE = 16'h001c;
  localparam logic [15:0] ADDR_SCAN_ST = 16'h0020;
  // CTRL fields
  localparam int CTRL_IVL_LSB = 0;
  localparam int CTRL_MBMODE_BIT = 16;
  // ENT_A: local in [11:0], count in [23:16], direction in bit 31
  localparam int ENT_CNT_LSB = 16;
  localparam int ENT_DIR_BIT = 31;
  localparam int ROUTE_W = 32;
endpackage

/* File: hw/tick_divider.sv */
// Divider making a one-cycle enable pulse every PERIOD clocks
`timescale 1ns/100ps
module tick_divider #(
  parameter int PERIOD = 1000000
) (
  input wire logic ref_clk,
  input wire logic nrst,
  output logic tick
);
  logic [31:0] cnt_q;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_q == 32'(PERIOD - 1)) begin
      cnt_q <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // tick_divider

/* File: hw/poll_table_scanner.sv */
// Periodic poll table scanner for one serial port
`timescale 1ns/100ps
module poll_table_scanner
  import poll_scan_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int PORT_ID = 0
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Poll request towards the message framer
  output logic req_valid,
  output logic req_write,
  output logic [5:0] req_entry,
  output logic [11:0] req_local,
  output logic [15:0] req_remote,
  output logic [7:0] req_count,
  output logic [ROUTE_W-1:0] req_route,
  input wire logic req_ack,
  // Reply from the framer
  input wire logic rsp_valid,
  input wire logic rsp_ok,
  output logic fixed_xfer_inhibit,
  output logic slave_refuse
);
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_STALL} scan_state_e;

  logic tick;
  logic [15:0] ivl_q;
  logic mbmode_q;
  logic [15:0] wd_timer_q;
  logic [4:0] wd_mask_q;
  logic [5:0] sel_q;
  logic [11:0] local_mem [ENTRIES];
  logic [15:0] remote_mem [ENTRIES];
  logic [7:0] count_mem [ENTRIES];
  logic dir_mem [ENTRIES];
  logic [ROUTE_W-1:0] route_mem [ENTRIES];
  logic [ENTRIES-1:0] valid_vec;
  logic [ENTRIES-1:0] status_q;
  logic [15:0] ivl_cnt_q;
  logic [15:0] stall_cnt_q;
  logic pending_q;
  logic [5:0] cur_q;
  logic [5:0] next_idx;
  logic next_found;
  scan_state_e state_q;
  logic port_shut;
  logic scan_en;
  logic wr_acc;
  logic wd_write;

  tick_divider #(.PERIOD(TICK_CYCLES)) u_tick (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tick(tick)
  );

  assign wr_acc = psel && penable && pwrite;
  assign wd_write = wr_acc && paddr == ADDR_WD_TIMER;
  // Shut while the timer sits at zero and this port is masked
  assign port_shut = wd_mask_q[PORT_ID] && wd_timer_q == 16'h0;
  assign scan_en = ivl_q != 16'h0 && !port_shut;

  // Entry validity: local, remote, count and route non-zero and in range
  always_comb begin
    for (int i = 0; i < ENTRIES; i++) begin
      valid_vec[i] = ((local_mem[i] >= 12'h001 &&
                       local_mem[i] <= LOCAL_LO_MAX) ||
                      (local_mem[i] >= LOCAL_HI_MIN &&
                       local_mem[i] <= LOCAL_HI_MAX)) &&
                     remote_mem[i] != 16'h0 &&
                     count_mem[i] != 8'h0 &&
                     count_mem[i] <= COUNT_MAX &&
                     route_mem[i] != '0;
    end
  end

  // Next valid entry after the current one, wrapping
  always_comb begin
    logic [6:0] k;
    k = 7'h0;
    next_idx = cur_q;
    next_found = 1'b0;
    for (int i = 1; i <= ENTRIES; i++) begin
      k = 7'((int'(cur_q) + i) % ENTRIES);
      if (!next_found && valid_vec[k[5:0]]) begin
        next_idx = k[5:0];
        next_found = 1'b1;
      end
    end
  end

  // APB writes to configuration
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ivl_q <= 16'h0;
      mbmode_q <= 1'b0;
      wd_mask_q <= WD_MASK_RST;
      sel_q <= 6'h0;
    end else if (wr_acc) begin
      unique case (paddr)
        ADDR_CTRL: begin
          ivl_q <= pwdata[CTRL_IVL_LSB +: 16];
          mbmode_q <= pwdata[CTRL_MBMODE_BIT];
        end
        ADDR_WD_MASK: wd_mask_q <= pwdata[4:0];
        ADDR_ENT_SEL: sel_q <= (pwdata[5:0] < 6'(ENTRIES)) ?
                               pwdata[5:0] : 6'h0;
        default: ;
      endcase
    end
  end

  // Table storage, one entry per index
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int i = 0; i < ENTRIES; i++) begin
        local_mem[i] <= 12'h0;
        remote_mem[i] <= 16'h0;
        count_mem[i] <= 8'h0;
        dir_mem[i] <= 1'b0;
        route_mem[i] <= '0;
      end
    end else if (wr_acc) begin
      if (paddr == ADDR_ENT_A) begin
        local_mem[sel_q] <= pwdata[11:0];
        count_mem[sel_q] <= pwdata[ENT_CNT_LSB +: 8];
        dir_mem[sel_q] <= pwdata[ENT_DIR_BIT];
      end else if (paddr == ADDR_ENT_B) begin
        remote_mem[sel_q] <= pwdata[15:0];
      end else if (paddr == ADDR_ENT_ROUTE) begin
        route_mem[sel_q] <= pwdata;
      end
    end
  end

  // Watchdog countdown; a write wins over the decrement
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wd_timer_q <= WD_TIMER_RST;
    end else if (wd_write) begin
      wd_timer_q <= pwdata[15:0];
    end else if (tick && wd_timer_q != 16'h0) begin
      wd_timer_q <= wd_timer_q - 16'h1;
    end
  end

  // APB read path and handshake, always answering in the access cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0;
        unique case (paddr)
          ADDR_CTRL: prdata <= {15'h0, mbmode_q, ivl_q};
          ADDR_STATUS0: prdata <= {16'h0, status_q[15:0]};
          ADDR_STATUS1: prdata <= {16'h0, status_q[31:16]};
          ADDR_STATUS2: prdata <= {16'h0, status_q[47:32]};
          ADDR_ENT_SEL: prdata <= {26'h0, sel_q};
          ADDR_ENT_A: prdata <= {dir_mem[sel_q], 7'h0, count_mem[sel_q],
                                 4'h0, local_mem[sel_q]};
          ADDR_ENT_B: prdata <= {16'h0, remote_mem[sel_q]};
          ADDR_ENT_ROUTE: prdata <= route_mem[sel_q];
          ADDR_SCAN_ST: prdata <= {24'h0, pending_q, port_shut,
                                   cur_q};
          ADDR_WD_TIMER: prdata <= {16'h0, wd_timer_q};
          ADDR_WD_MASK: prdata <= {27'h0, wd_mask_q};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Pacing engine
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      ivl_cnt_q <= 16'h0;
      stall_cnt_q <= 16'h0;
      cur_q <= 6'(ENTRIES - 1);
      req_valid <= 1'b0;
      pending_q <= 1'b0;
    end else if (!scan_en) begin
      state_q <= S_IDLE;
      ivl_cnt_q <= 16'h0;
      req_valid <= 1'b0;
      pending_q <= 1'b0;
    end else begin
      if (req_valid && req_ack) begin
        req_valid <= 1'b0;
      end
      if (rsp_valid) begin
        pending_q <= 1'b0;
      end
      unique case (state_q)
        S_IDLE: begin
          if (tick) begin
            ivl_cnt_q <= ivl_cnt_q + 16'h1;
          end
          if (ivl_cnt_q >= ivl_q && next_found && !req_valid) begin
            if (pending_q && !rsp_valid) begin
              state_q <= S_STALL;
              stall_cnt_q <= 16'h0;
            end else begin
              cur_q <= next_idx;
              req_valid <= 1'b1;
              pending_q <= 1'b1;
              ivl_cnt_q <= 16'h0;
            end
          end
        end
        S_STALL: begin
          if (tick) begin
            stall_cnt_q <= stall_cnt_q + 16'h1;
          end
          if (stall_cnt_q >= 16'(STALL_TICKS)) begin
            state_q <= S_IDLE;
            // The poll sent now is outstanding, so a late reply stalls again
            pending_q <= 1'b1;
            cur_q <= next_idx;
            req_valid <= 1'b1;
            ivl_cnt_q <= 16'h0;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Request fields follow the chosen entry
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      req_write <= 1'b0;
      req_entry <= 6'h0;
      req_local <= 12'h0;
      req_remote <= 16'h0;
      req_count <= 8'h0;
      req_route <= '0;
    end else begin
      req_entry <= cur_q;
      req_write <= dir_mem[cur_q];
      req_local <= local_mem[cur_q];
      req_remote <= remote_mem[cur_q];
      req_count <= count_mem[cur_q];
      req_route <= route_mem[cur_q];
    end
  end

  // Status bits; the reply loads rsp_ok, an invalid entry or shutdown clears
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      status_q <= '0;
    end else begin
      for (int i = 0; i < ENTRIES; i++) begin
        if (port_shut || !valid_vec[i]) begin
          status_q[i] <= 1'b0;
        end else if (rsp_valid && cur_q == 6'(i)) begin
          status_q[i] <= rsp_ok;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      fixed_xfer_inhibit <= 1'b0;
      slave_refuse <= 1'b0;
    end else begin
      fixed_xfer_inhibit <= |valid_vec;
      slave_refuse <= mbmode_q && scan_en && |valid_vec;
    end
  end

  property p_wd_zero_stops;
    @(posedge ref_clk) disable iff (!nrst)
      (wd_mask_q[PORT_ID] && wd_timer_q == 16'h0) |=> !req_valid;
  endproperty
  a_wd_zero_stops: assert property (p_wd_zero_stops)
    else $error("poll while shut");

  property p_ivl_zero;
    @(posedge ref_clk) disable iff (!nrst)
      ivl_q == 16'h0 |=> !req_valid;
  endproperty
  a_ivl_zero: assert property (p_ivl_zero)
    else $error("poll with zero interval");

  property p_timer_load;
    @(posedge ref_clk) disable iff (!nrst)
      wd_write |=> wd_timer_q == $past(pwdata[15:0]);
  endproperty
  a_timer_load: assert property (p_timer_load)
    else $error("timer not loaded");

  property p_timer_dec;
    @(posedge ref_clk) disable iff (!nrst)
      (tick && !wd_write && wd_timer_q != 16'h0) |=>
        wd_timer_q == $past(wd_timer_q) - 16'h1;
  endproperty
  a_timer_dec: assert property (p_timer_dec)
    else $error("timer not counting");

  property p_shut_status;
    @(posedge ref_clk) disable iff (!nrst)
      port_shut |=> status_q == '0;
  endproperty
  a_shut_status: assert property (p_shut_status)
    else $error("status kept");

  property p_req_valid_entry;
    @(posedge ref_clk) disable iff (!nrst)
      $rose(req_valid) |-> valid_vec[cur_q];
  endproperty
  a_req_valid_entry: assert property (p_req_valid_entry)
    else $error("invalid entry issued");

  property p_inhibit;
    @(posedge ref_clk) disable iff (!nrst)
      (|valid_vec) |=> fixed_xfer_inhibit;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("fixed transfer not inhibited");

  property p_status_set;
    @(posedge ref_clk) disable iff (!nrst)
      (rsp_valid && rsp_ok && !port_shut && valid_vec[cur_q]) |=>
        status_q[$past(cur_q)];
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("status not set");

  // Late reply at expiry parks the engine, then the stall ends in a poll
  sequence s_late_expiry;
    scan_en && state_q == S_IDLE && ivl_cnt_q >= ivl_q && next_found &&
      !req_valid && pending_q && !rsp_valid;
  endsequence
  sequence s_stall_done;
    scan_en && state_q == S_STALL && stall_cnt_q >= 16'(STALL_TICKS);
  endsequence
  property p_stall_entry;
    @(posedge ref_clk) disable iff (!nrst)
      s_late_expiry |=> state_q == S_STALL && !req_valid;
  endproperty
  a_stall_entry: assert property (p_stall_entry)
    else $error("no stall on late reply");

  property p_stall_issue;
    @(posedge ref_clk) disable iff (!nrst)
      s_stall_done |=> req_valid && pending_q;
  endproperty
  a_stall_issue: assert property (p_stall_issue)
    else $error("no poll after stall");
endmodule // poll_table_scanner

/* File: verification/framer_model.sv */
// Behavioural framer and remote slave answering the scanner's polls
`timescale 1ns/100ps
module framer_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic [5:0] req_entry,
  input wire logic slow,
  input wire logic [5:0] fail_entry,
  output logic req_ack,
  output logic rsp_valid,
  output logic rsp_ok
);
  logic seen_q;
  logic ok_q;
  int cnt_q;
  always_ff @(posedge ref_clk) begin
    req_ack <= 1'b0;
    rsp_valid <= 1'b0;
    // Outside a reply the flag toggles so nothing leans on a stale value
    rsp_ok <= ~rsp_ok;
    if (!nrst) begin
      seen_q <= 1'b0;
      cnt_q <= 0;
      rsp_ok <= 1'b0;
    end else begin
      seen_q <= req_valid && !req_ack;
      // Fields settle one cycle after the request rises, so ack one later
      if (seen_q && req_valid && !req_ack) begin
        req_ack <= 1'b1;
        seen_q <= 1'b0;
        ok_q <= (req_entry != fail_entry);
        cnt_q <= slow ? 50 : 4;
      end else if (cnt_q > 0) begin
        cnt_q <= cnt_q - 1;
        if (cnt_q == 1) begin
          rsp_valid <= 1'b1;
          rsp_ok <= ok_q; // error reply on one entry
        end
      end
    end
  end
endmodule // framer_model

/* File: verification/tb_top.sv */
// Self-checking bench for the poll table scanner
`timescale 1ns/100ps
module tb_top;
  import poll_scan_pkg::*;
  localparam int TC = 10;
  logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, req_valid, req_write, req_ack, rsp_valid, rsp_ok;
  logic fixed_xfer_inhibit, slave_refuse;
  logic [5:0] req_entry;
  logic [11:0] req_local;
  logic [15:0] req_remote;
  logic [7:0] req_count;
  logic [ROUTE_W-1:0] req_route;
  int n_fail = 0, tests_run = 0, cyc = 0, last_cyc = -1;
  int min_gap = 0, n_ack = 0, e;
  int seed = 32'hca04;
  logic [32:0] rd_q[$];
  logic [32:0] ex;
  int ent_q[$];
  logic [11:0] ex_loc[48];
  logic [15:0] ex_rem[48];
  logic [7:0] ex_cnt[48];
  logic [31:0] ex_rt[48];
  logic ex_dir[48];
  logic ex_ok[48];
  logic [47:0] st;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  poll_table_scanner #(.TICK_CYCLES(TC), .PORT_ID(0)) dut (
    .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
    .req_write(req_write), .req_entry(req_entry), .req_local(req_local),
    .req_remote(req_remote), .req_count(req_count), .req_route(req_route),
    .req_ack(req_ack), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
    .fixed_xfer_inhibit(fixed_xfer_inhibit), .slave_refuse(slave_refuse));
  framer_model pm (.ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid),
    .req_entry(req_entry), .slow(slow), .fail_entry(6'h05),
    .req_ack(req_ack), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok));
  task automatic chk(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic close_out();
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the watchdog process ends a wait that never completes
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input bit er, input logic [31:0] d);
    rd_q.push_back({er, d});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cfg(input int n, input int lo, input int c, input bit w,
                     input bit rz, input bit tz);
    ex_loc[n] = 12'(lo);
    ex_cnt[n] = 8'(c);
    ex_dir[n] = w;
    ex_rem[n] = rz ? 16'h0000 : 16'(($random(seed) & 32'h7fff) + 1);
    ex_rt[n] = tz ? 32'h0 : {16'h0000, 8'h29, 8'($random(seed)) | 8'h01};
    ex_ok[n] = ((lo >= 1 && lo <= 32) || (lo >= 65 && lo <= 2048)) &&
               !rz && c >= 1 && c <= 128 && !tz;
    apb(1'b1, ADDR_ENT_SEL, 32'(n));
    apb(1'b1, ADDR_ENT_A, {w, 7'h00, ex_cnt[n], 4'h0, ex_loc[n]});
    apb(1'b1, ADDR_ENT_B, {16'h0000, ex_rem[n]});
    apb(1'b1, ADDR_ENT_ROUTE, ex_rt[n]);
  endtask
  task automatic quiet(input int n);
    bit q;
    q = 1;
    repeat (n) begin
      @(negedge ref_clk);
      if (req_valid !== 1'b0) q = 0;
    end
    chk(q, "poll while disabled");
  endtask
  task automatic wait_ack(input int n);
    int t0, k;
    t0 = n_ack;
    k = 0;
    while (n_ack < t0 + n && k < 5000) begin
      @(negedge ref_clk);
      k++;
    end
    chk(n_ack >= t0 + n, "poll missing");
  endtask
  always @(negedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0) begin
      ex = rd_q.pop_front();
      chk(pslverr === ex[32] && (ex[32] || prdata === ex[31:0]), "read data");
    end
    if (req_valid === 1'b1 && req_ack === 1'b1) begin
      n_ack++;
      if (last_cyc >= 0) chk(cyc - last_cyc >= min_gap, "poll gap");
      last_cyc = cyc;
      if (ent_q.size() > 0) begin
        e = ent_q.pop_front();
        chk(req_entry === 6'(e) && req_write === ex_dir[e] &&
            req_local === ex_loc[e] && req_count === ex_cnt[e] &&
            req_remote === ex_rem[e] && req_route === ex_rt[e],
            "poll fields"); // order and fields
      end
    end
  end
  initial begin
    for (int i = 0; i < 48; i++) ex_ok[i] = 0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(ADDR_CTRL, 0, 32'h0); // interval zero after reset
    rd(ADDR_WD_TIMER, 0, 32'h0); // timer from reset
    rd(ADDR_WD_MASK, 0, 32'h0); // no port masked
    rd(16'h0100, 1, 32'h0);
    chk(fixed_xfer_inhibit === 1'b0, "inhibit empty"); // empty table
    cfg(0, 33, 4, 0, 0, 0); // gap local
    cfg(1, 1, 1, 0, 0, 0);
    cfg(2, 2049, 4, 1, 0, 0); // local above top
    cfg(3, 32, 128, 1, 0, 0); // count top
    cfg(4, 10, 4, 0, 1, 0); // zero remote
    cfg(5, 65, 7, 0, 0, 0);
    cfg(6, 10, 0, 1, 0, 0); // zero count
    cfg(7, 2048, 64, 1, 0, 0); // local top
    cfg(8, 10, 129, 0, 0, 0); // count above top
    cfg(9, 10, 4, 0, 0, 1); // zero route
    cfg(10, 64, 4, 1, 0, 0); // gap local
    cfg(20, 100, ($random(seed) & 127) + 1, 0, 0, 0);
    cfg(47, 500, 3, 1, 0, 0);
    repeat (2) @(negedge ref_clk);
    chk(fixed_xfer_inhibit === 1'b1, "inhibit"); // valid entry
    apb(1'b1, ADDR_CTRL, 32'h0001_0000);
    quiet(100); // zero interval
    chk(slave_refuse === 1'b0, "refuse idle"); // scanning off
    for (int r = 0; r < 2; r++)
      for (int i = 0; i < 48; i++) if (ex_ok[i]) ent_q.push_back(i);
    min_gap = 2 * TC;
    apb(1'b1, ADDR_CTRL, 32'h0001_0003);
    wait_ack(12); // two wrapped rounds
    chk(slave_refuse === 1'b1, "refuse"); // master only
    st = 48'h0;
    for (int i = 0; i < 48; i++) if (ex_ok[i] && i != 5) st[i] = 1'b1;
    rd(ADDR_STATUS0, 0, {16'h0000, st[15:0]}); // status words
    rd(ADDR_STATUS1, 0, {16'h0000, st[31:16]}); // status words
    rd(ADDR_STATUS2, 0, {16'h0000, st[47:32]}); // status words
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    repeat (2) @(negedge ref_clk);
    chk(slave_refuse === 1'b0, "refuse off"); // mode bit clear
    slow <= 1'b1;
    wait_ack(1); // slow reply starts
    min_gap = STALL_TICKS * TC - TC;
    wait_ack(2); // late reply stall
    slow <= 1'b0;
    wait_ack(1); // last stalled poll
    min_gap = 2 * TC;
    apb(1'b1, ADDR_WD_MASK, 32'h1e);
    wait_ack(1); // other ports masked
    apb(1'b1, ADDR_WD_MASK, 32'h01);
    repeat (10) @(negedge ref_clk);
    quiet(200); // timer at zero from reset stops port
    rd(ADDR_STATUS0, 0, 32'h0); // status cleared
    rd(ADDR_WD_MASK, 0, 32'h01); // mask readback
    apb(1'b1, ADDR_WD_TIMER, 32'd100);
    apb(1'b0, ADDR_WD_TIMER, 32'h0);
    chk(rv <= 32'd100 && rv >= 32'd98, "timer start"); // countdown
    wait_ack(1); // rewrite resumes polls
    repeat (1100) @(negedge ref_clk);
    rd(ADDR_WD_TIMER, 0, 32'h0); // holds at zero
    quiet(100); // expiry stops port
    apb(1'b0, ADDR_SCAN_ST, 32'h0);
    chk(rv[7:6] === 2'b01, "scan state"); // shut, none pending
    close_out();
  end
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
endmodule // tb_top
